// *** pkg/power_input_pkg.sv ***
/*
  Constants, register map and types shared by the pushbutton and
  watchdog input block. Assumes a 100 MHz mclk and a 32.768 kHz slow
  clock level that the block samples as an ordinary input.
*/
package power_input_pkg;

  // ----------------------------------------------------------------
  // Bus widths and register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int CNT_W = 24;
  localparam logic [7:0] OFS_INT_STATUS = 8'h00;
  localparam logic [7:0] OFS_INT_MASK = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_SENSE = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int NUM_INT = 2;
  localparam int INT_PRESS_BIT = 0;
  localparam int INT_RELEASE_BIT = 1;
  localparam int CFG_DBNC_LSB = 0;
  localparam int CFG_LONG_LSB = 2;
  localparam int SENSE_PRESSED_BIT = 0;
  localparam int SENSE_WDOG_BIT = 1;
  localparam int SENSE_STATE_LSB = 2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] INT_MASK_RST = 2'h3;
  localparam logic [1:0] DBNC_SEL_RST = 2'h0;
  localparam logic [1:0] LONG_SEL_RST = 2'h0;

  // ----------------------------------------------------------------
  // Timing, counted in slow clock cycles
  // ----------------------------------------------------------------
  localparam longint SLOW_CLK_HZ = 32768;
  localparam longint US_PER_S = 1000000;
  localparam longint DEB_SHORT_US = 31250;
  localparam longint DEB_MID_US = 125000;
  localparam longint DEB_LONG_US = 750000;
  localparam longint LONG_PRESS_STEP_S = 4;
  localparam logic [CNT_W-1:0] DEB_SHORT_TICKS =
    CNT_W'((DEB_SHORT_US * SLOW_CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam logic [CNT_W-1:0] DEB_MID_TICKS =
    CNT_W'((DEB_MID_US * SLOW_CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam logic [CNT_W-1:0] DEB_LONG_TICKS =
    CNT_W'((DEB_LONG_US * SLOW_CLK_HZ + US_PER_S - 1) / US_PER_S);
  localparam logic [CNT_W-1:0] LONG_PRESS_STEP_TICKS =
    CNT_W'(LONG_PRESS_STEP_S * SLOW_CLK_HZ);

  // Power states, Gray coded along off, start-up, run
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_START = 2'b01,
    ST_RUN = 2'b11
  } power_state_type;

endpackage

// *** pkg/debounce_if.sv ***
/*
  Carrier between the controller and the pushbutton filter.
  Assumes both ends sit on the same mclk domain.
*/
`timescale 1ns/100ps
interface debounce_if;
  import power_input_pkg::*;
  logic tick;
  logic pressed_raw;
  logic [CNT_W-1:0] fall_ticks;
  logic [CNT_W-1:0] rise_ticks;
  logic pressed;
  logic press_evt;
  logic release_evt;
  modport ctrl (output tick, pressed_raw, fall_ticks, rise_ticks,
                input pressed, press_evt, release_evt);
  modport filt (input tick, pressed_raw, fall_ticks, rise_ticks,
                output pressed, press_evt, release_evt);
endinterface

// *** hdl/pushbutton_filter.sv ***
/*
  Debounce filter for the synchronised pushbutton level.
  Assumes a one-cycle slow tick and thresholds given in slow ticks.
*/
`timescale 1ns/100ps
module pushbutton_filter
  import power_input_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  debounce_if.filt dbi
);

  logic stable_r;
  logic [CNT_W-1:0] cnt_r;
  logic press_r;
  logic release_r;
  logic differ;
  logic [CNT_W-1:0] limit;
  logic done;

  // Threshold picked by direction of the pending change
  assign differ = dbi.pressed_raw != stable_r;
  assign limit = stable_r ? dbi.rise_ticks : dbi.fall_ticks;
  assign done = differ && dbi.tick && (cnt_r + CNT_W'(1) >= limit);

  // -----------------------------------------------------------------
  // Stability counter
  // -----------------------------------------------------------------
  // Restarts whenever the input bounces back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!differ || done) begin
        cnt_r <= '0;
      end else if (dbi.tick) begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  // Accepted level and edge pulses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stable_r <= 1'b0;
      press_r <= 1'b0;
      release_r <= 1'b0;
    end else if (clk_en) begin
      press_r <= done && !stable_r;
      release_r <= done && stable_r;
      if (done) begin
        stable_r <= !stable_r;
      end
    end
  end

  assign dbi.pressed = stable_r;
  assign dbi.press_evt = press_r;
  assign dbi.release_evt = release_r;

endmodule // pushbutton_filter

// *** hdl/power_input_ctrl.sv ***
/*
  Watchdog shutdown and pushbutton handling with a classic Wishbone
  register slave, sticky interrupts and a small power state tracker.
  Assumes pins are synchronous to mclk, a free running 32.768 kHz
  level on slow_clock, and an outside sequencer reporting start-up.
*/
`timescale 1ns/100ps

// How it works
// - Watchdog low forces regulators off
// - Watchdog ignored until processor reset released
// - Pushbutton high released, low pressed
// - Long press beyond selected delay forces off
// - Codes 00/01 debounce all at 31.25 ms
// - Codes 10/11 lengthen press debounce only
// - Interrupt on debounced pushbutton press and release
// - Flag held until cleared or off state
// - Status read or write one clears; irq drops when none
// - Per-interrupt mask, all masked after reset
module power_input_ctrl
  import power_input_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEB_LONG_TICKS_P = DEB_LONG_TICKS,
  parameter logic [CNT_W-1:0] LONG_STEP_TICKS_P = LONG_PRESS_STEP_TICKS
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  output logic [DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic slow_clock,
  input wire logic pushbutton_input,
  input wire logic watchdog_shutdown_input,
  input wire logic sequence_done,
  output logic regulators_enable,
  output logic processor_reset_output_n,
  output logic interrupt_request_output
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  // Register indices, decoded once per access
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_MASK = 3'h1;
  localparam logic [2:0] IDX_CONFIG = 3'h2;
  localparam logic [2:0] IDX_SENSE = 3'h3;
  localparam logic [2:0] IDX_NONE = 3'h4;

  // Carrier to the pushbutton filter
  debounce_if dbi ();

  // Synchroniser stages and slow tick
  logic slow_meta_r;
  logic slow_sync_r;
  logic slow_prev_r;
  logic pb_meta_r;
  logic pb_sync_r;
  logic tick;

  // Power state tracker
  power_state_type state_r;
  power_state_type state_nxt;
  logic off_entry;

  // Long press timer
  logic [CNT_W-1:0] long_cnt_r;
  logic [CNT_W-1:0] long_limit;
  logic long_hit;

  // Interrupt flags and configuration
  logic [NUM_INT-1:0] status_r;
  logic [NUM_INT-1:0] status_nxt;
  logic [NUM_INT-1:0] mask_r;
  logic [NUM_INT-1:0] int_set;
  logic [NUM_INT-1:0] int_clr;
  logic [1:0] dbnc_sel_r;
  logic [1:0] long_sel_r;

  // Bus slave
  logic ack_r;
  logic [DAT_W-1:0] rd_data_r;
  logic req;
  logic wr_en;
  logic rd_en;
  logic [2:0] idx;
  logic [DAT_W-1:0] rd_mux;

  // Registered pins
  logic regs_en_r;
  logic reset_n_r;
  logic irq_r;

  // -----------------------------------------------------------------
  // Functions
  // -----------------------------------------------------------------
  // Byte address to register index
  function automatic logic [2:0] reg_index(input logic [ADR_W-1:0] adr);
    case (adr)
      OFS_INT_STATUS: reg_index = IDX_STATUS;
      OFS_INT_MASK: reg_index = IDX_MASK;
      OFS_CONFIG: reg_index = IDX_CONFIG;
      OFS_SENSE: reg_index = IDX_SENSE;
      default: reg_index = IDX_NONE;
    endcase
  endfunction

  // Press debounce length per select code
  function automatic logic [CNT_W-1:0] fall_limit(input logic [1:0] sel);
    case (sel)
      2'h2: fall_limit = DEB_MID_TICKS;
      2'h3: fall_limit = DEB_LONG_TICKS_P;
      default: fall_limit = DEB_SHORT_TICKS;
    endcase
  endfunction

  // Long press delay: one step per code, first step at code 0
  function automatic logic [CNT_W-1:0] press_limit(input logic [1:0] sel);
    logic [CNT_W-1:0] mult;
    mult = {{(CNT_W-2){1'b0}}, sel} + CNT_W'(1);
    press_limit = CNT_W'(mult * LONG_STEP_TICKS_P);
  endfunction

  // -----------------------------------------------------------------
  // Input synchronisers
  // -----------------------------------------------------------------
  // Slow clock level into mclk, third stage for edge detect
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slow_meta_r <= 1'b0;
      slow_sync_r <= 1'b0;
      slow_prev_r <= 1'b0;
    end else if (clk_en) begin
      slow_meta_r <= slow_clock;
      slow_sync_r <= slow_meta_r;
      slow_prev_r <= slow_sync_r;
    end
  end

  // Pushbutton, idle high means released
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pb_meta_r <= 1'b1;
      pb_sync_r <= 1'b1;
    end else if (clk_en) begin
      pb_meta_r <= pushbutton_input;
      pb_sync_r <= pb_meta_r;
    end
  end

  // One mclk pulse per slow rising edge
  assign tick = slow_sync_r && !slow_prev_r;

  // -----------------------------------------------------------------
  // Debounce filter
  // -----------------------------------------------------------------
  assign dbi.tick = tick;
  assign dbi.pressed_raw = !pb_sync_r;
  assign dbi.fall_ticks = fall_limit(dbnc_sel_r);
  assign dbi.rise_ticks = DEB_SHORT_TICKS;

  pushbutton_filter u_filter (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .dbi(dbi)
  );

  // -----------------------------------------------------------------
  // Long press timer
  // -----------------------------------------------------------------
  // Saturation keeps the hit level steady while held
  assign long_limit = press_limit(long_sel_r);
  assign long_hit = dbi.pressed && (long_cnt_r >= long_limit);

  // Counts slow ticks of a held press, saturating at the limit
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      long_cnt_r <= '0;
    end else if (clk_en) begin
      if (!dbi.pressed) begin
        long_cnt_r <= '0;
      end else if (tick && (long_cnt_r < long_limit)) begin
        long_cnt_r <= long_cnt_r + CNT_W'(1);
      end
    end
  end

  // -----------------------------------------------------------------
  // Power state tracker
  // -----------------------------------------------------------------
  // Turn-on by debounced press, turn-off by watchdog or long press
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (dbi.press_evt) begin
          state_nxt = ST_START;
        end
      end
      ST_START: begin
        if (long_hit) begin
          state_nxt = ST_OFF;
        end else if (sequence_done) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        // Watchdog honoured only once reset is released
        if (!watchdog_shutdown_input || long_hit) begin
          state_nxt = ST_OFF;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  // Leaving any on state; wipes the flags
  assign off_entry = (state_r != ST_OFF) && (state_nxt == ST_OFF);

  // State and the pins it drives
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
      regs_en_r <= 1'b0;
      reset_n_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      regs_en_r <= state_nxt != ST_OFF;
      reset_n_r <= state_nxt == ST_RUN;
    end
  end

  assign regulators_enable = regs_en_r;
  assign processor_reset_output_n = reset_n_r;

  // -----------------------------------------------------------------
  // Wishbone slave
  // -----------------------------------------------------------------
  // Ack gate stops a held strobe being taken twice
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_en = req && wb_we_i && wb_sel_i[0];
  assign rd_en = req && !wb_we_i;
  assign idx = reg_index(wb_adr_i);

  // Read data, unmapped reads return zero
  always_comb begin
    rd_mux = '0;
    case (idx)
      IDX_STATUS: rd_mux[NUM_INT-1:0] = status_r;
      IDX_MASK: rd_mux[NUM_INT-1:0] = mask_r;
      IDX_CONFIG: begin
        rd_mux[CFG_DBNC_LSB +: 2] = dbnc_sel_r;
        rd_mux[CFG_LONG_LSB +: 2] = long_sel_r;
      end
      IDX_SENSE: begin
        rd_mux[SENSE_PRESSED_BIT] = dbi.pressed;
        rd_mux[SENSE_WDOG_BIT] = watchdog_shutdown_input;
        rd_mux[SENSE_STATE_LSB +: 2] = state_r;
      end
      default: rd_mux = '0;
    endcase
  end

  // Answer one cycle after the request is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      rd_data_r <= '0;
    end else if (clk_en) begin
      ack_r <= req;
      if (rd_en) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_data_r;

  // Mask and configuration registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= INT_MASK_RST;
      dbnc_sel_r <= DBNC_SEL_RST;
      long_sel_r <= LONG_SEL_RST;
    end else if (clk_en) begin
      if (wr_en && (idx == IDX_MASK)) begin
        mask_r <= wb_dat_i[NUM_INT-1:0];
      end
      if (wr_en && (idx == IDX_CONFIG)) begin
        dbnc_sel_r <= wb_dat_i[CFG_DBNC_LSB +: 2];
        long_sel_r <= wb_dat_i[CFG_LONG_LSB +: 2];
      end
    end
  end

  // -----------------------------------------------------------------
  // Interrupt status
  // -----------------------------------------------------------------
  // Event pulses from the filter
  assign int_set[INT_PRESS_BIT] = dbi.press_evt;
  assign int_set[INT_RELEASE_BIT] = dbi.release_evt;

  // Sticky bits: set beats any clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INT; gi = gi + 1) begin : g_flag
      assign int_clr[gi] = off_entry
        || (rd_en && (idx == IDX_STATUS))
        || (wr_en && (idx == IDX_STATUS) && wb_dat_i[gi]);
      assign status_nxt[gi] = int_set[gi] || (status_r[gi] && !int_clr[gi]);
    end
  endgenerate

  // Status register and level interrupt
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else if (clk_en) begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & ~mask_r);
    end
  end

  // Report only; the processor acts on it
  assign interrupt_request_output = irq_r;

endmodule // power_input_ctrl

// *** tb/power_input_sva.sv ***
/* Assertions on the ports of power_input_ctrl.
   Assumes it is bound into the controller; clk_en may pause it. */
`timescale 1ns/100ps
module power_input_sva
  import power_input_pkg::*;
#(
  parameter logic [CNT_W-1:0] DEB_LONG_TICKS_P = DEB_LONG_TICKS,
  parameter logic [CNT_W-1:0] LONG_STEP_TICKS_P = LONG_PRESS_STEP_TICKS
)
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [DAT_W-1:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic slow_clock,
  input wire logic pushbutton_input,
  input wire logic watchdog_shutdown_input,
  input wire logic regulators_enable,
  input wire logic processor_reset_output_n,
  input wire logic interrupt_request_output
);
  // --------
  // Helpers
  // --------
  localparam logic [CNT_W-1:0] LONG_MIN = LONG_STEP_TICKS_P - 24'h2;
  logic take;
  logic slow_r;
  logic [1:0] mask_r;
  logic [1:0] dbnc_r;
  logic [CNT_W-1:0] press_min;
  logic [CNT_W-1:0] low_ticks_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;
  // Slow ticks counted while the pin is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slow_r <= 1'b0;
      low_ticks_r <= '0;
    end else begin
      slow_r <= slow_clock;
      if (pushbutton_input)
        low_ticks_r <= '0;
      else if (slow_clock && !slow_r && !(&low_ticks_r))
        low_ticks_r <= low_ticks_r + CNT_W'(1);
    end
  end
  // Copy of the mask, loaded where a write is taken
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      mask_r <= INT_MASK_RST;
    else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_INT_MASK)
      mask_r <= wb_dat_i[1:0];
  end
  // Copy of the debounce select, for the press qualification time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      dbnc_r <= DBNC_SEL_RST;
    else if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CONFIG)
      dbnc_r <= wb_dat_i[CFG_DBNC_LSB +: 2];
  end
  assign press_min = (dbnc_r == 2'h3) ? DEB_LONG_TICKS_P - 24'h2
    : (dbnc_r == 2'h2) ? DEB_MID_TICKS - 24'h2 : DEB_SHORT_TICKS - 24'h2;
  sequence bus_take;
    take;
  endsequence
  sequence status_clear;
    take && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_INT_STATUS && wb_dat_i[1:0] == 2'h3;
  endsequence
  sequence wdog_in_run;
    clk_en && processor_reset_output_n && !watchdog_shutdown_input;
  endsequence
  ack_answer_a: assert property (bus_take |=> wb_ack_o)
    else $error("bus request not answered");
  ack_pulse_a: assert property (wb_ack_o && clk_en |=> !wb_ack_o)
    else $error("ack held too long");
  wdog_off_a: assert property (wdog_in_run |-> ##[1:3] !regulators_enable)
    else $error("watchdog low did not switch off");
  wdog_masked_a: assert property (regulators_enable && !processor_reset_output_n && !watchdog_shutdown_input |=> regulators_enable)
    else $error("watchdog acted during start-up");
  irq_masked_a: assert property (mask_r == 2'h3 && $past(mask_r) == 2'h3 |-> !interrupt_request_output)
    else $error("masked flag raised irq");
  press_qual_a: assert property ($rose(regulators_enable) |-> low_ticks_r >= press_min)
    else $error("press accepted too early");
  long_press_a: assert property ($fell(regulators_enable) && $past(watchdog_shutdown_input, 2) && watchdog_shutdown_input |-> low_ticks_r >= LONG_MIN)
    else $error("switched off before long press");
  irq_clear_a: assert property (status_clear |-> ##[1:3] !interrupt_request_output)
    else $error("irq stayed after clear");
endmodule // power_input_sva

bind power_input_ctrl power_input_sva #(.DEB_LONG_TICKS_P(DEB_LONG_TICKS_P),
  .LONG_STEP_TICKS_P(LONG_STEP_TICKS_P)) chk (
  .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .slow_clock(slow_clock), .pushbutton_input(pushbutton_input),
  .watchdog_shutdown_input(watchdog_shutdown_input), .regulators_enable(regulators_enable),
  .processor_reset_output_n(processor_reset_output_n),
  .interrupt_request_output(interrupt_request_output));

// *** tb/switch_model.sv ***
/* Push-button switch with contact chatter.
   Assumes its inputs change just after mclk edges. */
`timescale 1ns/100ps
module switch_model (
  input wire logic mclk,
  input wire logic want_pressed,
  input wire logic [2:0] bounces,
  output logic pushbutton_input
);
  logic want_r = 1'b0;
  logic [6:0] bounce_cnt_r = 7'h00;
  initial pushbutton_input = 1'b1;
  // Chatter for sixteen cycles a bounce, then settle
  always @(posedge mclk) begin
    want_r <= want_pressed;
    if (want_r != want_pressed)
      bounce_cnt_r <= {bounces, 4'h0};
    else if (bounce_cnt_r != 7'h00)
      bounce_cnt_r <= bounce_cnt_r - 7'h01;
    pushbutton_input <= !want_pressed ^ bounce_cnt_r[3];
  end
endmodule // switch_model

// *** tb/power_input_ctrl_bench.sv ***
/* Bench for power_input_ctrl with a chattering switch model.
   Assumes a shortened long press step and slow clock. */
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch t=%0t got %0h want %0h", $time, (got), (exp)); end end
module power_input_ctrl_bench;
  import power_input_pkg::*;
  localparam logic [CNT_W-1:0] DLONG = 24'h28;
  localparam logic [CNT_W-1:0] STEP = 24'h5DC;
  localparam int SP = 6;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic slow_clock = 1'b0;
  logic [2:0] slow_div = 3'h0;
  logic pb;
  logic wdog = 1'b1;
  logic clk_en = 1'b1;
  logic seq_done = 1'b0;
  logic want = 1'b0;
  logic [2:0] bounces = 3'h0;
  logic regs_en;
  logic rst_out_n;
  logic irq;
  int n_mismatch = 0;
  int tests_run = 0;
  int seed = 32'h6650;
  always #5 mclk = ~mclk;
  // Slow clock of six mclk periods
  always @(posedge mclk) begin
    slow_div <= (slow_div == 3'h5) ? 3'h0 : slow_div + 3'h1;
    slow_clock <= (slow_div < 3'h3);
  end
  power_input_ctrl #(.DEB_LONG_TICKS_P(DLONG), .LONG_STEP_TICKS_P(STEP)) dut (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .slow_clock(slow_clock), .pushbutton_input(pb),
    .watchdog_shutdown_input(wdog), .sequence_done(seq_done), .regulators_enable(regs_en),
    .processor_reset_output_n(rst_out_n), .interrupt_request_output(irq));
  switch_model sw (.mclk(mclk), .want_pressed(want), .bounces(bounces),
    .pushbutton_input(pb));
  // ----------
  // Bench tasks
  // ----------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] r);
    @(posedge mclk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
    // Wait for the answer; only the watchdog ends a hang
    do begin
      @(posedge mclk);
    end while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, 4'hF, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, 4'hF, r);
    `CHK(r, e)
  endtask
  task automatic wait_on(input logic k, input logic v, input int lim, output int n);
    n = 0;
    while ((k ? irq : regs_en) !== v && n < lim) begin
      @(posedge mclk);
      n++;
    end
  endtask
  // Switch change with random chatter
  task automatic act(input logic p);
    logic [2:0] b;
    b = 3'($random(seed) & 3);
    @(posedge mclk);
    want <= p;
    bounces <= b;
    repeat (16 * b + 4) @(posedge mclk);
  endtask
  function automatic logic in_win(input int n, input int t, input int x);
    return n >= t * SP - 30 && n <= (t + x) * SP + 30;
  endfunction
  function automatic int press_t(input logic [1:0] c);
    return c == 2'h3 ? int'(DLONG) : c == 2'h2 ? int'(DEB_MID_TICKS) : int'(DEB_SHORT_TICKS);
  endfunction
  initial begin
    #800000;
    n_mismatch++;
    give_verdict();
  end
  // ----------
  // Scenarios
  // ----------
  initial begin
    int n;
    int tot;
    logic [31:0] r;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(OFS_INT_STATUS, 32'h0);
    rd_chk(OFS_INT_MASK, 32'h3);
    rd_chk(OFS_CONFIG, 32'h0);
    rd_chk(OFS_SENSE, 32'h2);
    rd_chk(8'h10, 32'h0);
    wr(OFS_CONFIG, {28'($random(seed)), 4'hC});
    xfer(1'b1, OFS_CONFIG, 32'h3, 4'hE, r);
    rd_chk(OFS_CONFIG, 32'hC);
    wr(OFS_INT_MASK, 32'h0);
    // Glitch, then a press with code 00
    act(1'b1);
    repeat (200) @(posedge mclk);
    act(1'b0);
    act(1'b1);
    wait_on(1'b0, 1'b1, 12000, n);
    `CHK(in_win(n, press_t(2'h0), 0), 1'b1)
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b1)
    rd_chk(OFS_INT_STATUS, 32'h1);
    rd_chk(OFS_SENSE, 32'h7);
    // Release with code 01, watchdog pulse in start-up
    wr(OFS_CONFIG, 32'hD);
    act(1'b0);
    wdog <= 1'b0;
    repeat (6) @(posedge mclk);
    wdog <= 1'b1;
    `CHK(regs_en, 1'b1)
    wait_on(1'b1, 1'b1, 12000, n);
    `CHK(in_win(n, press_t(2'h1), 0), 1'b1)
    wr(OFS_INT_STATUS, 32'h3);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0)
    rd_chk(OFS_INT_STATUS, 32'h0);
    seq_done <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(rst_out_n, 1'b1)
    rd_chk(OFS_SENSE, 32'hE);
    wdog <= 1'b0;
    wait_on(1'b0, 1'b0, 4, n);
    `CHK(regs_en, 1'b0)
    `CHK(rst_out_n, 1'b0)
    wdog <= 1'b1;
    // Code 10: 125 ms press debounce, short release
    wr(OFS_CONFIG, 32'hE);
    act(1'b1);
    wait_on(1'b0, 1'b1, 30000, n);
    `CHK(in_win(n, press_t(2'h2), 0), 1'b1)
    rd_chk(OFS_INT_STATUS, 32'h1);
    act(1'b0);
    wait_on(1'b1, 1'b1, 12000, n);
    `CHK(in_win(n, press_t(2'h0), 0), 1'b1)
    repeat (20) @(posedge mclk);
    `CHK(irq, 1'b1)
    // Frozen by clk_en: watchdog low must wait
    clk_en <= 1'b0;
    wdog <= 1'b0;
    repeat (6) @(posedge mclk);
    `CHK(regs_en, 1'b1)
    `CHK(irq, 1'b1)
    clk_en <= 1'b1;
    repeat (6) @(posedge mclk);
    wdog <= 1'b1;
    `CHK(irq, 1'b0)
    rd_chk(OFS_INT_STATUS, 32'h0);
    // Code 11 and a long press of one step
    wr(OFS_CONFIG, 32'h3);
    act(1'b1);
    wait_on(1'b0, 1'b1, 2000, n);
    `CHK(in_win(n, press_t(2'h3), 0), 1'b1)
    tot = n;
    wait_on(1'b0, 1'b0, 12000, n);
    tot = tot + n;
    `CHK(in_win(tot, int'(STEP), int'(DLONG)), 1'b1)
    rd_chk(OFS_INT_STATUS, 32'h0);
    act(1'b0);
    wait_on(1'b1, 1'b1, 12000, n);
    `CHK(in_win(n, press_t(2'h0), 0), 1'b1)
    // Masked flag stays readable but keeps irq low
    wr(OFS_INT_MASK, 32'h3);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(OFS_INT_MASK, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b1)
    rd_chk(OFS_INT_STATUS, 32'h2);
    give_verdict();
  end
endmodule // power_input_ctrl_bench
